// File: adsr_pkg.sv
package adsr_pkg;
  // one 16-bit setup, field positions within the half word
  localparam int SETUP_W       = 16;
  localparam int UPPER_LSB     = 16;
  localparam int CHAN_LSB      = 14;
  localparam int GAIN_LSB      = 11;
  localparam int RATE_LSB      = 7;
  localparam int POL_BIT       = 6;
  localparam int LATCH_LSB     = 4;
  localparam int DELAY_BIT     = 3;
  localparam int OPEN_BIT      = 2;
  localparam int PTR_LSB       = 0;
  localparam int NUM_CHAN      = 4;
  localparam int GAIN_FRAC_BITS = 24;

  // register kinds on the command port
  localparam logic [1:0] KIND_SETUP  = 2'h0;
  localparam logic [1:0] KIND_OFFSET = 2'h1;
  localparam logic [1:0] KIND_GAIN   = 2'h2;

  // reset values and implemented bits
  localparam logic [31:0] SETUP_RST        = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RST       = 32'h0000_0000;
  localparam logic [31:0] GAIN_RST         = 32'h0100_0000;
  localparam logic [31:0] GAIN_USED_MASK   = 32'h3FFF_FFFF;
  localparam logic [31:0] OFFSET_USED_MASK = 32'hFFFF_FF00;

  // reference master clock for the tabulated rates, in Hz
  localparam int MCLK_REF_HZ = 4915200;

  // conversion start delay, master clock cycles
  localparam logic [10:0] DELAY_CYC_STD    = 11'h500;
  localparam logic [10:0] DELAY_CYC_SCALED = 11'h600;

  // word period in master clock cycles for code x000 of each group
  localparam logic [19:0] PERIOD_FAST_STD    = 20'h00500;
  localparam logic [19:0] PERIOD_FAST_SCALED = 20'h00600;
  localparam logic [19:0] PERIOD_SLOW_STD    = 20'h0A000;
  localparam logic [19:0] PERIOD_SLOW_SCALED = 20'h0C000;
  localparam logic [2:0]  RATE_STEP_MAX      = 3'h4;

  typedef enum logic [2:0] {
    DLY_IDLE = 3'b001,
    DLY_WAIT = 3'b010,
    DLY_FIRE = 3'b100
  } adsr_dly_state_e;
endpackage

// File: adsr_setup_if.sv
`timescale 1ns/1ns
interface adsr_setup_if;
  logic [1:0]  chan;
  logic [6:0]  gain_factor;
  logic [3:0]  rate_code;
  logic        rate_valid;
  logic [19:0] period;
  logic        unipolar;
  logic [1:0]  latch;
  logic        delay_en;
  logic        open_en;
  logic [1:0]  pointer;

  modport prod (output chan, gain_factor, rate_code, rate_valid, period, unipolar, latch,
                output delay_en, open_en, pointer);
  modport cons (input chan, gain_factor, rate_code, rate_valid, period, unipolar, latch,
                input delay_en, open_en, pointer);
endinterface

// File: adsr_setup_decode.sv
`timescale 1ns/1ns
module adsr_setup_decode (
  input  wire logic [15:0] i_setup,
  input  wire logic        i_rate_scale_sel,
  adsr_setup_if.prod       o_fields
);
  import adsr_pkg::*;

  logic [19:0] base;

  always_comb begin
    o_fields.chan        = i_setup[CHAN_LSB +: 2];
    // code 111 names no gain and decodes to zero
    o_fields.gain_factor = 7'h01 << i_setup[GAIN_LSB +: 3];
    o_fields.rate_code   = i_setup[RATE_LSB +: 4];
    o_fields.rate_valid  = (i_setup[RATE_LSB +: 3] <= RATE_STEP_MAX);
    if (i_setup[RATE_LSB + 3]) begin
      base = i_rate_scale_sel ? PERIOD_FAST_SCALED : PERIOD_FAST_STD;
    end else begin
      base = i_rate_scale_sel ? PERIOD_SLOW_SCALED : PERIOD_SLOW_STD;
    end
    // period in master clocks, so true rate tracks the master clock linearly
    o_fields.period      = o_fields.rate_valid ? (base << i_setup[RATE_LSB +: 3]) : 20'h00000;
    o_fields.unipolar    = i_setup[POL_BIT];
    o_fields.latch       = i_setup[LATCH_LSB +: 2];
    o_fields.delay_en    = i_setup[DELAY_BIT];
    o_fields.open_en     = i_setup[OPEN_BIT];
    o_fields.pointer     = i_setup[PTR_LSB +: 2];
  end
endmodule

// File: adsr_start_delay.sv
`timescale 1ns/1ns
module adsr_start_delay (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start,
  input  wire logic i_delay_en,
  input  wire logic i_rate_scale_sel,
  input  wire logic i_mclk_tick,
  output logic      o_go
);
  import adsr_pkg::*;

  typedef struct packed {
    adsr_dly_state_e st;
    logic [10:0]     cnt;
    logic            go;
  } adsr_dly_s;

  adsr_dly_s s_q;
  adsr_dly_s s_d;

  always_comb begin
    s_d    = s_q;
    s_d.go = 1'b0;
    case (s_q.st)
      DLY_IDLE: begin
        if (i_start && i_delay_en) begin
          s_d.cnt = i_rate_scale_sel ? DELAY_CYC_SCALED : DELAY_CYC_STD;
          s_d.st  = DLY_WAIT;
        end else if (i_start) begin
          s_d.st = DLY_FIRE;
        end
      end
      DLY_WAIT: begin
        // a new command cancels the wait and returns to idle, firing no start
        if (i_start) begin
          s_d.st = DLY_IDLE;
        end else if (i_mclk_tick) begin
          s_d.cnt = s_q.cnt - 11'h001;
          if (s_q.cnt == 11'h001) begin
            s_d.st = DLY_FIRE;
          end
        end
      end
      DLY_FIRE: begin
        s_d.go = 1'b1;
        s_d.st = DLY_IDLE;
      end
      default: s_d.st = DLY_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q <= '{st: DLY_IDLE, cnt: 11'h000, go: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_go = s_q.go;
endmodule

// File: adsr_regs.sv
`timescale 1ns/1ns
module adsr_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [1:0]  i_reg_kind,
  input  wire logic [1:0]  i_reg_idx,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_exec,
  input  wire logic [2:0]  i_exec_setup,
  input  wire logic        i_exec_continuous,
  input  wire logic        i_latch_source_sel,
  input  wire logic        i_cal_pointer_source_sel,
  input  wire logic        i_rate_scale_sel,
  input  wire logic [1:0]  i_cfg_latch_bits,
  input  wire logic        i_mclk_tick,
  output logic [31:0]      o_rd_data,
  output logic             o_rd_valid,
  output logic             o_latch_out_first,
  output logic             o_latch_out_second,
  output logic [1:0]       o_phys_channel_sel,
  output logic [6:0]       o_gain_factor,
  output logic [3:0]       o_output_rate_code,
  output logic             o_rate_valid,
  output logic [19:0]      o_word_period,
  output logic             o_unipolar,
  output logic [3:0]       o_open_circuit_current_en,
  output logic [1:0]       o_cal_index,
  output logic [31:0]      o_active_gain,
  output logic [31:0]      o_active_offset,
  output logic             o_offset_negative,
  output logic [31:0]      o_scaled_offset,
  output logic             o_long_conv,
  output logic             o_conv_start
);
  import adsr_pkg::*;

  typedef struct packed {
    logic [NUM_CHAN-1:0][31:0] setup;
    logic [NUM_CHAN-1:0][31:0] offset;
    logic [NUM_CHAN-1:0][31:0] gain;
    logic [31:0]               rd_data;
    logic                      rd_valid;
    logic [1:0]                latch;
    logic [1:0]                chan;
    logic [6:0]                gain_factor;
    logic [3:0]                rate_code;
    logic                      rate_valid;
    logic [19:0]               period;
    logic                      unipolar;
    logic [3:0]                open_en;
    logic [1:0]                cal_idx;
    logic [31:0]               act_gain;
    logic [31:0]               act_offset;
    logic [31:0]               scaled_offset;
    logic                      long_conv;
    logic                      running;
  } adsr_regs_s;

  adsr_regs_s s_q;
  adsr_regs_s s_d;

  adsr_setup_if fld ();

  logic [15:0]        sel_setup;
  logic [1:0]         pair;
  logic signed [62:0] prod;

  // even-numbered setup (index bit 0 clear) sits in the upper half
  always_comb begin
    pair      = i_exec_setup[2:1];
    sel_setup = i_exec_setup[0] ? s_q.setup[pair][SETUP_W-1:0]
                                : s_q.setup[pair][UPPER_LSB +: SETUP_W];
  end

  adsr_setup_decode u_decode (
    .i_setup          (sel_setup),
    .i_rate_scale_sel (i_rate_scale_sel),
    .o_fields         (fld.prod)
  );

  adsr_start_delay u_delay (
    .i_sys_clk        (i_sys_clk),
    .i_rst_n          (i_rst_n),
    .i_start          (i_exec),
    .i_delay_en       (fld.delay_en),
    .i_rate_scale_sel (i_rate_scale_sel),
    .i_mclk_tick      (i_mclk_tick),
    .o_go             (o_conv_start)
  );

  // gain has bits 29:0 only, so the product never needs the sign of gain
  assign prod = $signed(s_q.act_offset) * $signed({1'b0, s_q.act_gain[29:0]});

  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;

    if (i_wr_en) begin
      if (i_reg_kind == KIND_SETUP) begin
        s_d.setup[i_reg_idx] = i_wr_data;
      end else if (i_reg_kind == KIND_OFFSET) begin
        s_d.offset[i_reg_idx] = i_wr_data & OFFSET_USED_MASK;
      end else if (i_reg_kind == KIND_GAIN) begin
        s_d.gain[i_reg_idx] = i_wr_data & GAIN_USED_MASK;
      end
    end

    if (i_rd_en) begin
      s_d.rd_valid = 1'b1;
      if (i_reg_kind == KIND_SETUP) begin
        s_d.rd_data = s_q.setup[i_reg_idx];
      end else if (i_reg_kind == KIND_OFFSET) begin
        s_d.rd_data = s_q.offset[i_reg_idx];
      end else if (i_reg_kind == KIND_GAIN) begin
        s_d.rd_data = s_q.gain[i_reg_idx] & GAIN_USED_MASK;
      end else begin
        s_d.rd_data = 32'h0000_0000;
      end
    end

    // fields of a setup take effect only when a command names it
    if (i_exec) begin
      s_d.chan        = fld.chan;
      s_d.gain_factor = fld.gain_factor;
      s_d.rate_code   = fld.rate_code;
      s_d.rate_valid  = fld.rate_valid;
      s_d.period      = fld.period;
      s_d.unipolar    = fld.unipolar;
      s_d.open_en     = fld.open_en ? (4'h1 << fld.chan) : 4'h0;
      s_d.cal_idx     = i_cal_pointer_source_sel ? fld.pointer : fld.chan;
      s_d.latch       = i_latch_source_sel ? i_cfg_latch_bits : fld.latch;
      // single conversions and the first of a continuous run carry filter settling
      s_d.long_conv   = !i_exec_continuous || !s_q.running;
      s_d.running     = i_exec_continuous;
    end

    s_d.act_gain      = s_q.gain[s_q.cal_idx];
    s_d.act_offset    = s_q.offset[s_q.cal_idx];
    s_d.scaled_offset = prod[GAIN_FRAC_BITS +: 32];
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q               <= '0;
      s_q.setup         <= {NUM_CHAN{SETUP_RST}};
      s_q.offset        <= {NUM_CHAN{OFFSET_RST}};
      s_q.gain          <= {NUM_CHAN{GAIN_RST}};
      s_q.act_gain      <= GAIN_RST;
      s_q.act_offset    <= OFFSET_RST;
      s_q.gain_factor   <= 7'h01;
      s_q.rate_valid    <= 1'b1;
      s_q.period        <= PERIOD_SLOW_STD;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    o_rd_data                 = s_q.rd_data;
    o_rd_valid                = s_q.rd_valid;
    o_latch_out_first         = s_q.latch[1];
    o_latch_out_second        = s_q.latch[0];
    o_phys_channel_sel        = s_q.chan;
    o_gain_factor             = s_q.gain_factor;
    o_output_rate_code        = s_q.rate_code;
    o_rate_valid              = s_q.rate_valid;
    o_word_period             = s_q.period;
    o_unipolar                = s_q.unipolar;
    o_open_circuit_current_en = s_q.open_en;
    o_cal_index               = s_q.cal_idx;
    o_active_gain             = s_q.act_gain;
    o_active_offset           = s_q.act_offset;
    o_offset_negative         = s_q.act_offset[31];
    o_scaled_offset           = s_q.scaled_offset;
    o_long_conv               = s_q.long_conv;
  end
endmodule

// File: adsr_regs_monitor.sv
`timescale 1ns/1ns
module adsr_regs_monitor
  import adsr_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_rd_en,
  input wire logic [1:0]  i_reg_kind,
  input wire logic        i_exec,
  input wire logic        i_latch_source_sel,
  input wire logic        i_cal_pointer_source_sel,
  input wire logic        i_rate_scale_sel,
  input wire logic [1:0]  i_cfg_latch_bits,
  input wire logic [31:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic        o_latch_out_first,
  input wire logic        o_latch_out_second,
  input wire logic [1:0]  o_phys_channel_sel,
  input wire logic [3:0]  o_output_rate_code,
  input wire logic        o_rate_valid,
  input wire logic [19:0] o_word_period,
  input wire logic [3:0]  o_open_circuit_current_en,
  input wire logic [1:0]  o_cal_index,
  input wire logic [31:0] o_active_gain
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  function automatic logic [19:0] per_f(input logic s, input logic [3:0] c);
    per_f = (c[3] ? (s ? PERIOD_FAST_SCALED : PERIOD_FAST_STD)
                  : (s ? PERIOD_SLOW_SCALED : PERIOD_SLOW_STD)) << c[2:0];
  endfunction
  property p_rdv; i_rd_en |=> o_rd_valid ##1 (o_rd_valid == $past(i_rd_en)); endproperty
  a_rdv: assert property (p_rdv) else $error("bad read valid");
  property p_top; i_rd_en && i_reg_kind == KIND_GAIN |=> o_rd_data[31:30] == 2'h0; endproperty
  a_top: assert property (p_top) else $error("gain top bits set");
  property p_unm; i_rd_en && i_reg_kind == 2'h3 |=> o_rd_data == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_lat;
    i_exec && i_latch_source_sel |=>
      {o_latch_out_first, o_latch_out_second} == $past(i_cfg_latch_bits);
  endproperty
  a_lat: assert property (p_lat) else $error("latch pins wrong");
  property p_per;
    i_exec ##1 o_rate_valid |-> o_word_period == per_f($past(i_rate_scale_sel), o_output_rate_code);
  endproperty
  a_per: assert property (p_per) else $error("word period wrong");
  property p_oc;
    o_open_circuit_current_en != 4'h0 |-> o_open_circuit_current_en == 4'(1 << o_phys_channel_sel);
  endproperty
  a_oc: assert property (p_oc) else $error("open current wrong");
  property p_cal; i_exec && !i_cal_pointer_source_sel |=> o_cal_index == o_phys_channel_sel; endproperty
  a_cal: assert property (p_cal) else $error("cal index wrong");
  // reset itself is the cause here, so this one is never disabled
  property p_rst; disable iff (1'b0) !i_rst_n |=> o_active_gain == GAIN_RST; endproperty
  a_rst: assert property (p_rst) else $error("reset gain wrong");
  c_exec: cover property (i_exec ##1 o_rate_valid);
  c_read: cover property (i_rd_en && i_reg_kind == KIND_GAIN ##1 o_rd_valid);
  c_open: cover property (o_open_circuit_current_en != 4'h0);
endmodule

// File: adsr_host.sv
`timescale 1ns/1ns
module adsr_host
  import adsr_pkg::*;
(
  input  wire logic        i_sys_clk,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [1:0]       o_kind,
  output logic [1:0]       o_idx,
  output logic [31:0]      o_data,
  output logic             o_exec,
  output logic [2:0]       o_setup
);
  initial begin
    {o_wr_en, o_rd_en, o_kind, o_idx, o_data, o_exec, o_setup} = '0;
  end
  task automatic req(input logic w, input logic [1:0] k, input logic [1:0] x,
                     input logic [31:0] d);
    // a host never programs a gain above 40, so larger values are clipped
    if (w && k == KIND_GAIN && d[29:0] > 30'h2800_0000) begin
      d = 32'h2800_0000;
    end
    @(posedge i_sys_clk);
    #1;
    {o_wr_en, o_rd_en, o_kind, o_idx, o_data} = {w, !w, k, x, d};
    @(posedge i_sys_clk);
    #1;
    {o_wr_en, o_rd_en} = 2'h0;
  endtask
  task automatic run(input logic [2:0] s);
    @(posedge i_sys_clk);
    #1;
    {o_exec, o_setup} = {1'b1, s};
    @(posedge i_sys_clk);
    #1;
    o_exec = 1'b0;
  endtask
endmodule

// File: adsr_regs_test.sv
`timescale 1ns/1ns
module adc_setup_and_calibration_regs_test;
  import adsr_pkg::*;
  logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_exec_continuous = 1'b0, i_mclk_tick = 1'b1;
  logic        i_latch_source_sel = 1'b0, i_cal_pointer_source_sel = 1'b0, i_rate_scale_sel = 1'b0;
  logic        i_wr_en, i_rd_en, i_exec, o_rd_valid, o_latch_out_first, o_latch_out_second;
  logic        o_rate_valid, o_unipolar, o_offset_negative, o_long_conv, o_conv_start;
  logic [1:0]  i_reg_kind, i_reg_idx, i_cfg_latch_bits, o_phys_channel_sel, o_cal_index, ch;
  logic [2:0]  i_exec_setup;
  logic [3:0]  o_output_rate_code, o_open_circuit_current_en;
  logic [6:0]  o_gain_factor;
  logic [15:0] h;
  logic [19:0] o_word_period;
  logic [31:0] i_wr_data, o_rd_data, o_active_gain, o_active_offset, o_scaled_offset, off;
  logic [42:0] exp_lo;
  logic [3:0]  rates [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  int          mismatches = 0, compares = 0, n;
  always #10 i_sys_clk = ~i_sys_clk;
  adsr_regs uut (.i_sys_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_reg_kind, .i_reg_idx, .i_wr_data,
    .i_exec, .i_exec_setup, .i_exec_continuous, .i_latch_source_sel, .i_cal_pointer_source_sel,
    .i_rate_scale_sel, .i_cfg_latch_bits, .i_mclk_tick, .o_rd_data, .o_rd_valid,
    .o_latch_out_first, .o_latch_out_second, .o_phys_channel_sel, .o_gain_factor,
    .o_output_rate_code, .o_rate_valid, .o_word_period, .o_unipolar, .o_open_circuit_current_en,
    .o_cal_index, .o_active_gain, .o_active_offset, .o_offset_negative, .o_scaled_offset,
    .o_long_conv, .o_conv_start);
  adsr_host host (.i_sys_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_kind(i_reg_kind),
    .o_idx(i_reg_idx), .o_data(i_wr_data), .o_exec(i_exec), .o_setup(i_exec_setup));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [1:0] k, input logic [1:0] x, input logic [31:0] e);
    host.req(1'b0, k, x, 32'h0);
    chk({o_rd_valid, o_rd_data}, {1'b1, e});
  endtask
  function automatic logic [42:0] expf(input logic [15:0] s);
    logic [19:0] p;
    p = (s[10] ? (i_rate_scale_sel ? 20'h00600 : 20'h00500)
               : (i_rate_scale_sel ? 20'h0C000 : 20'h0A000)) << s[9:7];
    expf = {s[15:14], 7'(1 << s[13:11]), s[10:7], 1'b1, p, s[6],
            i_latch_source_sel ? i_cfg_latch_bits : s[5:4], s[2] ? 4'(1 << s[15:14]) : 4'h0,
            i_cal_pointer_source_sel ? s[1:0] : s[15:14]};
  endfunction
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdchk(KIND_GAIN, 2'(i), 32'h0100_0000);
      rdchk(KIND_OFFSET, 2'(i), 32'h0);
      rdchk(KIND_SETUP, 2'(i), 32'h0);
    end
    host.req(1'b1, KIND_GAIN, 2'h0, 32'hE800_0000);
    rdchk(KIND_GAIN, 2'h0, 32'h2800_0000);
    host.req(1'b1, 2'h3, 2'h0, 32'hFFFF_FFFF);
    rdchk(2'h3, 2'h0, 32'h0);
    host.req(1'b1, KIND_OFFSET, 2'h1, 32'h8000_00FF);
    rdchk(KIND_OFFSET, 2'h1, 32'h8000_0000);
    // positive offset of one against the gain of 40 shows the scaling
    host.req(1'b1, KIND_OFFSET, 2'h0, 32'h0100_0000);
    for (int i = 0; i < 10; i++) begin
      ch = 2'(i);
      h = {ch, 3'(i % 7), rates[i], i[0], 2'(i + 1), 1'b0, i[0], ~ch};
      i_latch_source_sel = i[0];
      i_cal_pointer_source_sel = i[1];
      i_rate_scale_sel = i[2];
      i_cfg_latch_bits = 2'(~i);
      host.req(1'b1, KIND_SETUP, ch, {h, h ^ 16'hC000});
      host.run({ch, 1'b0});
      chk({o_phys_channel_sel, o_gain_factor, o_output_rate_code, o_rate_valid, o_word_period,
           o_unipolar, o_latch_out_first, o_latch_out_second, o_open_circuit_current_en,
           o_cal_index}, expf(h));
      host.run({ch, 1'b1});
      exp_lo = expf(h ^ 16'hC000);
      chk({o_phys_channel_sel, o_cal_index}, {~ch, exp_lo[1:0]});
      @(posedge i_sys_clk);
      #1;
      // only channel two's setup points at the negative offset written above
      off = (ch == 2'h2) ? 32'h8000_0000 : 32'h0;
      chk({o_conv_start, o_long_conv, o_offset_negative, o_active_gain},
          {2'b11, off[31], (ch == 2'h3) ? 32'h2800_0000 : 32'h0100_0000});
      @(posedge i_sys_clk);
      #1;
      chk(o_scaled_offset, (ch == 2'h3) ? 32'h2800_0000 : off);
    end
    // a continuous run is long only on its first command
    i_exec_continuous = 1'b1;
    host.run(3'h0);
    chk(o_long_conv, 1);
    host.run(3'h1);
    chk(o_long_conv, 0);
    i_exec_continuous = 1'b0;
    for (int s = 0; s < 2; s++) begin
      i_rate_scale_sel = s[0];
      host.req(1'b1, KIND_SETUP, 2'h3, 32'h0008_0000);
      host.run(3'h6);
      n = 0;
      while (o_conv_start !== 1'b1 && n < 2000) begin
        @(posedge i_sys_clk);
        #1;
        n++;
      end
      chk(n >= (s ? 1536 : 1280) && n <= (s ? 1540 : 1284), 1);
    end
    complete_run();
  end
endmodule
bind adsr_regs adsr_regs_monitor mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_rd_en(i_rd_en), .i_reg_kind(i_reg_kind), .i_exec(i_exec),
  .i_latch_source_sel(i_latch_source_sel), .i_cal_pointer_source_sel(i_cal_pointer_source_sel),
  .i_rate_scale_sel(i_rate_scale_sel), .i_cfg_latch_bits(i_cfg_latch_bits),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_latch_out_first(o_latch_out_first),
  .o_latch_out_second(o_latch_out_second), .o_phys_channel_sel(o_phys_channel_sel),
  .o_output_rate_code(o_output_rate_code), .o_rate_valid(o_rate_valid),
  .o_word_period(o_word_period), .o_open_circuit_current_en(o_open_circuit_current_en),
  .o_cal_index(o_cal_index), .o_active_gain(o_active_gain));
